/* File: hw/servo_frame_defines.svh */
// Constants for the servo reference-frame and homing block
`ifndef SERVO_FRAME_DEFINES_SVH
`define SERVO_FRAME_DEFINES_SVH
// Register offsets (word addresses)
`define REG_CTRL       4'h0
`define REG_STATUS     4'h1
`define REG_IRQ_STAT   4'h2
`define REG_IRQ_MASK   4'h3
`define REG_SW_CMD     4'h4
`define REG_TARGET     4'h5
`define REG_HOME_VALUE 4'h6
`define REG_HOME_CFG   4'h7
`define REG_RATIO      4'h8
`define REG_STAMP      4'h9
`define REG_COMMAND    4'ha
// Control register bits
`define CTRL_ENABLE    0
`define CTRL_EXT_REF   1
// Command register bits (write-one pulses)
`define CMD_BEGIN      0
`define CMD_BEGIN_IN   1
`define CMD_RELATIVE   2
`define CMD_ABSOLUTE   3
`define CMD_JOG        4
`define CMD_HOME_ARM   5
// Interrupt bits
`define IRQ_HOMED      0
`define IRQ_STOPPED    1
`define IRQ_LAUNCH     2
`define IRQ_WIDTH      3
// Timing
`define CLK_HZ         40000000
`define SAMPLE_US      200
`define STAMP_US_DIV   40
`endif

/* File: hw/servo_frame_pkg.sv */
// Types shared by the servo reference-frame block
package servo_frame_pkg;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_PTP = 2'b01,
    MODE_JOG = 2'b11
  } motion_mode_t;
  typedef enum logic [1:0] {
    HOME_IDLE = 2'b00,
    HOME_ARMED = 2'b01,
    HOME_DONE = 2'b11
  } home_state_t;
  typedef enum logic [3:0] {
    SRC_HOME_HI = 4'h1, SRC_HOME_LO = 4'h2, SRC_INDEX_HI = 4'h3, SRC_INDEX_LO = 4'h4,
    SRC_RLS_HI = 4'h5, SRC_RLS_LO = 4'h6, SRC_FLS_HI = 4'h7, SRC_FLS_LO = 4'h8,
    SRC_IN1_HI = 4'h9, SRC_IN1_LO = 4'ha, SRC_IN2_HI = 4'hb, SRC_IN2_LO = 4'hc,
    SRC_IN3_HI = 4'hd, SRC_IN3_LO = 4'he
  } home_src_t;
endpackage

/* File: hw/pin_sync.sv */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_reg;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_reg[i] <= 1'b0;
          pin_sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= pin_in[i];
          pin_sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule // pin_sync

/* File: hw/sample_tick.sv */
// Sampling-period and microsecond tick generator
`timescale 1ns/10ps
`include "servo_frame_defines.svh"
module sample_tick #(
  parameter int SAMPLE_CYCLES = `CLK_HZ / 1000000 * `SAMPLE_US,
  parameter int US_CYCLES = `STAMP_US_DIV
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic sample_tick_out,
  output logic us_tick_out
);
  logic [15:0] samp_reg;
  logic [7:0] us_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      samp_reg <= 16'h0000;
      sample_tick_out <= 1'b0;
    end else if (samp_reg == 16'(SAMPLE_CYCLES - 1)) begin
      samp_reg <= 16'h0000;
      sample_tick_out <= 1'b1;
    end else begin
      samp_reg <= samp_reg + 16'h0001;
      sample_tick_out <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      us_reg <= 8'h00;
      us_tick_out <= 1'b0;
    end else if (us_reg == 8'(US_CYCLES - 1)) begin
      us_reg <= 8'h00;
      us_tick_out <= 1'b1;
    end else begin
      us_reg <= us_reg + 8'h01;
      us_tick_out <= 1'b0;
    end
  end
endmodule // sample_tick

/* File: hw/servo_frame_homing.sv */
// Servo reference-frame management and homing event logic
// Summary of operation
// - Motor enable loads the software reference so the total reference equals the position.
// - After that load the software command stays constant until a motion is accepted.
// - After enable no motion mode is defined and a begin command launches nothing.
// - With external reference on, the enable load is main position minus ratio times aux.
// - Relative tracking sets the software command to main position minus external command.
// - After relative tracking the command is still and the mode undefined until a mode command.
// - Relative tracking cancels a begin that is pending on an input event.
// - Motor enable performs the whole relative-tracking initialisation.
// - The external selector drops the external term when clear and adds it when set.
// - Only a launched point-to-point motion makes tracking absolute; jog does not.
// - A switch set up as a stop source halts motion whatever the external selector is.
// - On the expected homing event a known value is loaded into the position counter.
// - The homing source is one of reverse/forward limit, home, index or digital inputs.
// - Limit and digital-input events are seen once per sampling period.
// - Home and index events are stamped to the microsecond.
// - Homing events are serviced by this logic in real time, not by software polling.
`timescale 1ns/10ps
`include "servo_frame_defines.svh"
module servo_frame_homing
  import servo_frame_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int SAMPLE_CYCLES = `CLK_HZ / 1000000 * `SAMPLE_US
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic [POS_W-1:0] main_position_counter,
  input wire logic [POS_W-1:0] auxiliary_position_counter,
  input wire logic reverse_limit_switch,
  input wire logic forward_limit_switch,
  input wire logic home_switch,
  input wire logic encoder_index,
  input wire logic [2:0] digital_in,
  input wire logic stop_switch,
  output logic [POS_W-1:0] position_reference,
  output logic motion_active,
  output logic position_load,
  output logic [POS_W-1:0] position_load_value
);
  // ----------------------------------------------------------------
  // Pin synchronisation and ticks
  // ----------------------------------------------------------------
  logic [7:0] pins_s;
  logic sample_tick_w;
  logic us_tick_w;
  pin_sync #(.WIDTH(8)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({stop_switch, digital_in, encoder_index, home_switch,
             forward_limit_switch, reverse_limit_switch}),
    .pin_sync_out(pins_s)
  );
  sample_tick #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .US_CYCLES(`STAMP_US_DIV)) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .sample_tick_out(sample_tick_w),
    .us_tick_out(us_tick_w)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic motor_enable_cmd_reg;
  logic external_reference_select_reg;
  logic [POS_W-1:0] sw_cmd_reg;
  logic [POS_W-1:0] target_reg;
  logic [POS_W-1:0] home_value_reg;
  logic [3:0] home_src_reg;
  logic [15:0] follower_ratio_reg;
  logic [31:0] stamp_reg;
  logic [31:0] us_count_reg;
  logic [`IRQ_WIDTH-1:0] irq_stat_reg;
  logic [`IRQ_WIDTH-1:0] irq_mask_reg;
  motion_mode_t mode_reg;
  home_state_t home_reg;
  logic pending_begin_reg;
  logic absolute_reg;
  logic stopped_reg;
  logic [7:0] pins_d_reg;
  logic in1_tick_reg;

  logic ctrl_wr;
  logic cmd_wr;
  logic motor_enable_rise;
  logic begin_motion_cmd;
  logic begin_on_input_cmd;
  logic relative_tracking_cmd;
  logic absolute_target_cmd;
  logic jog_velocity_cmd;
  logic home_arm_cmd;
  logic launch;
  logic input_event;
  assign ctrl_wr = reg_wr && reg_addr == `REG_CTRL;
  assign cmd_wr = reg_wr && reg_addr == `REG_COMMAND;
  assign motor_enable_rise = ctrl_wr && reg_wdata[`CTRL_ENABLE] && !motor_enable_cmd_reg;
  assign begin_motion_cmd = cmd_wr && reg_wdata[`CMD_BEGIN];
  assign begin_on_input_cmd = cmd_wr && reg_wdata[`CMD_BEGIN_IN];
  assign relative_tracking_cmd = cmd_wr && reg_wdata[`CMD_RELATIVE];
  assign absolute_target_cmd = cmd_wr && reg_wdata[`CMD_ABSOLUTE];
  assign jog_velocity_cmd = cmd_wr && reg_wdata[`CMD_JOG];
  assign home_arm_cmd = cmd_wr && reg_wdata[`CMD_HOME_ARM];

  // ----------------------------------------------------------------
  // External reference term and frame re-initialisation
  // ----------------------------------------------------------------
  logic [POS_W-1:0] ext_cmd;
  logic [POS_W+15:0] ratio_prod;
  logic frame_init;
  logic [POS_W-1:0] ext_init;
  assign ratio_prod = $signed(auxiliary_position_counter) * $signed({1'b0, follower_ratio_reg});
  assign ext_cmd = external_reference_select_reg ? ratio_prod[POS_W-1:0] : '0;
  assign ext_init = (ctrl_wr ? reg_wdata[`CTRL_EXT_REF] : external_reference_select_reg) ?
                    ratio_prod[POS_W-1:0] : '0;
  assign frame_init = motor_enable_rise || (relative_tracking_cmd && motor_enable_cmd_reg);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      motor_enable_cmd_reg <= 1'b0;
      external_reference_select_reg <= 1'b0;
    end else if (ctrl_wr) begin
      motor_enable_cmd_reg <= reg_wdata[`CTRL_ENABLE];
      external_reference_select_reg <= reg_wdata[`CTRL_EXT_REF];
    end
  end
  // Software command stays frozen except on init or a launched move
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_cmd_reg <= '0;
    end else if (frame_init) begin
      sw_cmd_reg <= main_position_counter - ext_init;
    end else if (launch && mode_reg == MODE_PTP) begin
      sw_cmd_reg <= target_reg;
    end
  end
  // Reference is continuous: position at init equals sw + ext
  assign position_reference = sw_cmd_reg + ext_cmd;

  // ----------------------------------------------------------------
  // Motion mode, begin and stop handling
  // ----------------------------------------------------------------
  // In1 is compared against its value at the previous tick, so a rise still high at the next tick is not missed
  assign input_event = sample_tick_w && pins_s[4] && !in1_tick_reg;
  assign launch = motor_enable_cmd_reg && mode_reg != MODE_NONE && !stopped_reg &&
                  (begin_motion_cmd || (pending_begin_reg && input_event));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_NONE;
    end else if (frame_init || !motor_enable_cmd_reg) begin
      mode_reg <= MODE_NONE;
    end else if (absolute_target_cmd) begin
      mode_reg <= MODE_PTP;
    end else if (jog_velocity_cmd) begin
      mode_reg <= MODE_JOG;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      target_reg <= '0;
    end else if (reg_wr && reg_addr == `REG_TARGET) begin
      target_reg <= reg_wdata[POS_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pending_begin_reg <= 1'b0;
    end else if (relative_tracking_cmd || frame_init || launch) begin
      pending_begin_reg <= 1'b0;
    end else if (begin_on_input_cmd) begin
      pending_begin_reg <= 1'b1;
    end
  end
  // Only a point-to-point launch makes the frame absolute
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      absolute_reg <= 1'b0;
    end else if (frame_init || stopped_reg) begin
      absolute_reg <= 1'b0;
    end else if (launch && mode_reg == MODE_PTP) begin
      absolute_reg <= 1'b1;
    end
  end
  // A stop is sticky until relative tracking or a motor enable rise; host must re-frame first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      motion_active <= 1'b0;
      stopped_reg <= 1'b0;
    end else if (frame_init) begin
      motion_active <= 1'b0;
      stopped_reg <= 1'b0;
    end else if (pins_s[7]) begin
      motion_active <= 1'b0;
      stopped_reg <= stopped_reg || motion_active;
    end else if (launch) begin
      motion_active <= 1'b1;
    end else if (!motor_enable_cmd_reg) begin
      motion_active <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Homing
  // ----------------------------------------------------------------
  logic home_hit;
  logic fast_src;
  logic lvl;
  always_comb begin
    lvl = 1'b0;
    case (home_src_t'(home_src_reg))
      SRC_HOME_HI: lvl = pins_s[2];
      SRC_HOME_LO: lvl = !pins_s[2];
      SRC_INDEX_HI: lvl = pins_s[3] && !pins_d_reg[3];
      SRC_INDEX_LO: lvl = !pins_s[3] && pins_d_reg[3];
      SRC_RLS_HI: lvl = pins_s[0];
      SRC_RLS_LO: lvl = !pins_s[0];
      SRC_FLS_HI: lvl = pins_s[1];
      SRC_FLS_LO: lvl = !pins_s[1];
      SRC_IN1_HI: lvl = pins_s[4];
      SRC_IN1_LO: lvl = !pins_s[4];
      SRC_IN2_HI: lvl = pins_s[5];
      SRC_IN2_LO: lvl = !pins_s[5];
      SRC_IN3_HI: lvl = pins_s[6];
      SRC_IN3_LO: lvl = !pins_s[6];
      default: lvl = 1'b0;
    endcase
  end
  assign fast_src = home_src_reg >= 4'h1 && home_src_reg <= 4'h4;
  // Slow sources only looked at on the sampling tick
  assign home_hit = home_reg == HOME_ARMED && lvl && (fast_src || sample_tick_w);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pins_d_reg <= 8'h00;
      in1_tick_reg <= 1'b0;
    end else begin
      pins_d_reg <= pins_s;
      if (sample_tick_w) in1_tick_reg <= pins_s[4];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      home_reg <= HOME_IDLE;
    end else begin
      case (home_reg)
        HOME_IDLE: if (home_arm_cmd) home_reg <= HOME_ARMED;
        HOME_ARMED: if (home_hit) home_reg <= HOME_DONE;
        HOME_DONE: home_reg <= HOME_IDLE;
        default: home_reg <= HOME_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      position_load <= 1'b0;
      position_load_value <= '0;
    end else begin
      position_load <= home_hit;
      position_load_value <= home_value_reg;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      us_count_reg <= 32'h0000_0000;
      stamp_reg <= 32'h0000_0000;
    end else begin
      if (us_tick_w) us_count_reg <= us_count_reg + 32'h0000_0001;
      if (home_hit) stamp_reg <= us_count_reg;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      home_value_reg <= '0;
      home_src_reg <= 4'h0;
      follower_ratio_reg <= 16'h0000;
      irq_mask_reg <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_HOME_VALUE: home_value_reg <= reg_wdata[POS_W-1:0];
        `REG_HOME_CFG: home_src_reg <= reg_wdata[3:0];
        `REG_RATIO: follower_ratio_reg <= reg_wdata[15:0];
        `REG_IRQ_MASK: irq_mask_reg <= reg_wdata[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and read port
  // ----------------------------------------------------------------
  logic [`IRQ_WIDTH-1:0] irq_set;
  logic stat_rd;
  assign irq_set = {launch, pins_s[7] && motion_active, home_hit};
  assign stat_rd = reg_rd && reg_addr == `REG_IRQ_STAT;
  // Set wins over read-clear so no event is lost
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (stat_rd ? '0 : irq_stat_reg) | irq_set;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= {30'h0, external_reference_select_reg, motor_enable_cmd_reg};
        `REG_STATUS: reg_rdata <= {24'h0, home_reg, stopped_reg, absolute_reg,
                                   pending_begin_reg, motion_active, mode_reg};
        `REG_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_reg};
        `REG_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_reg};
        `REG_SW_CMD: reg_rdata <= sw_cmd_reg;
        `REG_TARGET: reg_rdata <= target_reg;
        `REG_HOME_VALUE: reg_rdata <= home_value_reg;
        `REG_HOME_CFG: reg_rdata <= {28'h0, home_src_reg};
        `REG_RATIO: reg_rdata <= {16'h0, follower_ratio_reg};
        `REG_STAMP: reg_rdata <= stamp_reg;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_enable_load: assert property (@(posedge clk_sys) disable iff (rst)
    motor_enable_rise |=> sw_cmd_reg == $past(main_position_counter) - $past(ext_init))
    else $error("enable load wrong");
  chk_cmd_frozen: assert property (@(posedge clk_sys) disable iff (rst)
    (!frame_init && !launch) |=> $stable(sw_cmd_reg))
    else $error("software command moved");
  chk_no_mode_launch: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == MODE_NONE |-> !launch)
    else $error("launch without mode");
  chk_relative_mode: assert property (@(posedge clk_sys) disable iff (rst)
    frame_init |=> mode_reg == MODE_NONE && !motion_active)
    else $error("mode not cleared");
  chk_pending_clear: assert property (@(posedge clk_sys) disable iff (rst)
    relative_tracking_cmd |=> !pending_begin_reg)
    else $error("pending begin kept");
  chk_jog_relative: assert property (@(posedge clk_sys) disable iff (rst)
    (launch && mode_reg == MODE_JOG && !absolute_reg) |=> !absolute_reg)
    else $error("jog set absolute");
  chk_stop_halts: assert property (@(posedge clk_sys) disable iff (rst)
    (pins_s[7] && !frame_init) |=> !motion_active)
    else $error("stop ignored");
  chk_home_load: assert property (@(posedge clk_sys) disable iff (rst)
    home_hit |=> position_load && position_load_value == $past(home_value_reg))
    else $error("home load missing");
  chk_slow_sample: assert property (@(posedge clk_sys) disable iff (rst)
    (home_hit && !fast_src) |-> sample_tick_w)
    else $error("slow event off tick");
endmodule // servo_frame_homing

/* File: test/motor_env.sv */
// Behavioural model of the motor side: position counters, switch pins and stop switch
`timescale 1ns/10ps
module motor_env (
  input wire logic clk_sys,
  input wire logic position_load,
  input wire logic [31:0] position_load_value,
  output logic [31:0] main_position_counter,
  output logic [31:0] auxiliary_position_counter,
  output logic [6:0] pins,
  output logic stop_switch
);
  // ----------------------------------------
  // Counters and pins
  // ----------------------------------------
  // Pins: 0 home, 1 index, 2 reverse limit, 3 forward limit, 4..6 digital in1..in3
  // The bench moves the axis by writing these variables after a clock edge
  initial begin
    main_position_counter = 32'h0;
    auxiliary_position_counter = 32'h0;
    pins = 7'h00;
    stop_switch = 1'b0;
  end
  // The counter takes the homing value at the edge where the load pulse stands
  always @(posedge clk_sys) begin
    if (position_load) begin
      main_position_counter <= position_load_value;
    end
  end
endmodule // motor_env

/* File: test/servo_reference_frame_homing_tb.sv */
// Self-checking bench for the servo reference-frame and homing block
`timescale 1ns/10ps
`include "servo_frame_defines.svh"
module servo_reference_frame_homing_tb;
  import servo_frame_pkg::*;
  // Short sampling period keeps the slow-source waits brief
  localparam int SC = 10;
  logic clk_sys, rst, reg_wr, reg_rd, irq, motion_active, position_load, stop_switch;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ref_pos, load_val, px, py;
  logic [6:0] pins;
  int checks, bad_count;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  motor_env i_env (.clk_sys(clk_sys), .position_load(position_load),
    .position_load_value(load_val), .main_position_counter(px),
    .auxiliary_position_counter(py), .pins(pins), .stop_switch(stop_switch));
  servo_frame_homing #(.POS_W(32), .SAMPLE_CYCLES(SC)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .main_position_counter(px),
    .auxiliary_position_counter(py), .reverse_limit_switch(pins[2]),
    .forward_limit_switch(pins[3]), .home_switch(pins[0]), .encoder_index(pins[1]),
    .digital_in(pins[6:4]), .stop_switch(stop_switch), .position_reference(ref_pos),
    .motion_active(motion_active), .position_load(position_load),
    .position_load_value(load_val));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic set_pos(input logic [31:0] x, input logic [31:0] y);
    @(posedge clk_sys);
    i_env.main_position_counter <= x;
    i_env.auxiliary_position_counter <= y;
  endtask
  task automatic wait_act(input logic e);
    for (int i = 0; i < 20 && motion_active !== e; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk32("motion_active", {31'h0, e}, {31'h0, motion_active});
    if (motion_active !== e) wrap_up();
  endtask
  task automatic idle_check;
    repeat (4) @(posedge clk_sys);
    #1 chk32("motion_active idle", 0, {31'h0, motion_active});
  endtask
  task automatic stop_axis;
    @(posedge clk_sys);
    i_env.stop_switch <= 1'b1;
    wait_act(1'b0);
    @(posedge clk_sys);
    i_env.stop_switch <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    rd(`REG_STATUS, d);
    chk32("status", 0, d);
    rd(`REG_SW_CMD, d);
    chk32("sw_cmd", 0, d);
    rd(4'hf, d);
    chk32("unmapped read", 0, d);
    chk32("irq", 0, {31'h0, irq});
    $display("test reset done");
  endtask
  task automatic t_enable_ptp;
    logic [31:0] d;
    set_pos(32'd1000, 32'd0);
    wr(`REG_CTRL, 32'h1);
    rd(`REG_SW_CMD, d);
    chk32("sw_cmd", 32'd1000, d);
    chk32("position_reference", 32'd1000, ref_pos);
    rd(`REG_STATUS, d);
    chk32("status", 0, d);
    wr(`REG_COMMAND, 32'h1 << `CMD_BEGIN);
    idle_check();
    set_pos(32'd1010, 32'd0);
    rd(`REG_SW_CMD, d);
    chk32("sw_cmd held", 32'd1000, d);
    wr(`REG_TARGET, 32'h0);
    wr(`REG_IRQ_MASK, 32'h1 << `IRQ_LAUNCH);
    wr(`REG_COMMAND, 32'h1 << `CMD_ABSOLUTE);
    rd(`REG_STATUS, d);
    chk32("mode", {30'h0, MODE_PTP}, d & 32'h3);
    wr(`REG_COMMAND, 32'h1 << `CMD_BEGIN);
    wait_act(1'b1);
    rd(`REG_STATUS, d);
    chk32("absolute", 32'h10, d & 32'h10);
    chk32("irq", 1, {31'h0, irq});
    rd(`REG_IRQ_STAT, d);
    chk32("irq_stat", 32'h4, d);
    chk32("irq cleared", 0, {31'h0, irq});
    stop_axis();
    rd(`REG_STATUS, d);
    chk32("stopped", 32'h20, d & 32'h20);
    wr(`REG_COMMAND, 32'h1 << `CMD_RELATIVE);
    rd(`REG_STATUS, d);
    chk32("stopped clear", 0, d & 32'h33);
    $display("test enable and ptp done");
  endtask
  task automatic t_external;
    logic [31:0] d;
    wr(`REG_CTRL, 32'h0);
    wr(`REG_RATIO, 32'h1);
    set_pos(32'd1000, 32'd3000);
    wr(`REG_CTRL, 32'h3);
    rd(`REG_SW_CMD, d);
    chk32("sw_cmd ext", -32'd2000, d);
    chk32("position_reference", 32'd1000, ref_pos);
    set_pos(32'd1000, 32'd3500);
    repeat (2) @(posedge clk_sys);
    #1 chk32("position_reference", 32'd1500, ref_pos);
    wr(`REG_CTRL, 32'h1);
    #1 chk32("position_reference off", -32'd2000, ref_pos);
    wr(`REG_CTRL, 32'h3);
    wr(`REG_COMMAND, 32'h1 << `CMD_ABSOLUTE);
    wr(`REG_COMMAND, 32'h1 << `CMD_BEGIN_IN);
    rd(`REG_STATUS, d);
    chk32("pending", 32'h8, d & 32'h8);
    wr(`REG_COMMAND, 32'h1 << `CMD_RELATIVE);
    rd(`REG_SW_CMD, d);
    chk32("sw_cmd relative", -32'd2500, d);
    rd(`REG_STATUS, d);
    chk32("pending and mode", 0, d & 32'hb);
    wr(`REG_COMMAND, 32'h1 << `CMD_BEGIN);
    idle_check();
    wr(`REG_COMMAND, 32'h1 << `CMD_JOG);
    wr(`REG_COMMAND, 32'h1 << `CMD_BEGIN);
    wait_act(1'b1);
    rd(`REG_STATUS, d);
    chk32("jog not absolute", {30'h0, MODE_JOG}, d & 32'h13);
    stop_axis();
    wr(`REG_COMMAND, 32'h1 << `CMD_RELATIVE);
    wr(`REG_COMMAND, 32'h1 << `CMD_ABSOLUTE);
    wr(`REG_COMMAND, 32'h1 << `CMD_BEGIN_IN);
    idle_check();
    @(posedge clk_sys);
    i_env.pins[4] <= 1'b1;
    wait_act(1'b1);
    rd(`REG_STATUS, d);
    chk32("input launch absolute", 32'h10, d & 32'h18);
    stop_axis();
    wr(`REG_COMMAND, 32'h1 << `CMD_RELATIVE);
    i_env.pins[4] <= 1'b0;
    rd(`REG_IRQ_STAT, d);
    $display("test external reference done");
  endtask
  // Every source: pin parked inactive, armed, then driven to its active level
  task automatic t_homing;
    logic [31:0] d;
    int n;
    int p;
    wr(`REG_IRQ_MASK, 32'h1 << `IRQ_HOMED);
    for (int src = 1; src <= 14; src++) begin
      p = (src - 1) / 2;
      @(posedge clk_sys);
      i_env.pins[p] <= ~src[0];
      wr(`REG_HOME_VALUE, src * 32'h111);
      wr(`REG_HOME_CFG, src);
      repeat (SC + 4) @(posedge clk_sys);
      wr(`REG_COMMAND, 32'h1 << `CMD_HOME_ARM);
      repeat (SC) @(posedge clk_sys);
      rd(`REG_STATUS, d);
      chk32("home armed", {24'h0, HOME_ARMED, 6'h0}, d & 32'hc0);
      @(posedge clk_sys);
      i_env.pins[p] <= src[0];
      n = 0;
      while (position_load !== 1'b1 && n < 3 * SC) begin
        @(posedge clk_sys);
        #1 n++;
      end
      chk32("position_load", 1, {31'h0, position_load});
      if (position_load !== 1'b1) wrap_up();
      chk32("load value", src * 32'h111, load_val);
      if (src <= 4) begin
        chk32("fast latency", 1, {31'h0, n <= 4});
      end else begin
        chk32("sampled latency", 1, {31'h0, n <= SC + 5});
      end
      @(posedge clk_sys);
      #1 chk32("counter loaded", src * 32'h111, px);
      chk32("irq homed", 1, {31'h0, irq});
      rd(`REG_IRQ_STAT, d);
      chk32("irq_stat homed", 1, d & 32'h1);
      i_env.pins[p] <= 1'b0;
    end
    $display("test homing done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    checks = 0;
    bad_count = 0;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_enable_ptp();
    t_external();
    t_homing();
    wrap_up();
  end
endmodule // servo_reference_frame_homing_tb
